// ===== core/sbscd_pkg.sv
// constants and types shared by the sensor bus slave command decoder
package sbscd_pkg;

    // command codes carried in the 4-bit command field
    localparam logic [3:0] CODE_INIT = 4'h0;
    localparam logic [3:0] CODE_REV_INIT = 4'hF;
    localparam logic [3:0] CODE_CLEAR = 4'h7;
    localparam logic [3:0] CODE_FORMAT = 4'hA;

    // address field value that reaches every slave
    localparam logic [3:0] GLOBAL_ADDR = 4'h0;

    // bit positions inside the 8-bit command data field
    localparam int NIB_HI = 3;
    localparam int NIB_LO = 0;
    localparam int INIT_SWITCH_BIT = 6;
    localparam int FMT_RW_BIT = 7;
    localparam int FMT_IDX_HI = 6;
    localparam int FMT_IDX_LO = 4;

    // format register indices
    localparam logic [2:0] IDX_TAPS_LO = 3'h0;
    localparam logic [2:0] IDX_TAPS_HI = 3'h1;
    localparam logic [2:0] IDX_SEED_LO = 3'h2;
    localparam logic [2:0] IDX_SEED_HI = 3'h3;
    localparam logic [2:0] IDX_CHECK_LEN = 3'h4;
    localparam logic [2:0] IDX_SHORT_LEN = 3'h5;
    localparam logic [2:0] IDX_RESERVED = 3'h6;
    localparam logic [2:0] IDX_SELECT = 3'h7;
    localparam int FMT_REGS = 8;

    // standard-format values loaded at reset and on clear
    localparam logic [3:0] RST_TAPS_LO = 4'h1;
    localparam logic [3:0] RST_TAPS_HI = 4'h1;
    localparam logic [3:0] RST_SEED_LO = 4'hA;
    localparam logic [3:0] RST_SEED_HI = 4'h0;
    localparam logic [3:0] RST_CHECK_LEN = 4'h4;
    localparam logic [3:0] RST_SHORT_LEN = 4'h8;
    localparam logic [3:0] RST_RESERVED = 4'h0;
    localparam logic [3:0] RST_SELECT = 4'h0;

    // legal ranges and selection codes
    localparam logic [3:0] CHECK_LEN_MAX = 4'h8;
    localparam logic [3:0] SHORT_LEN_MIN = 4'h8;
    localparam logic [3:0] SEL_CUSTOM = 4'hF;
    localparam logic [3:0] SEL_STANDARD = 4'h0;

    // clock edges after reset release before the strap is taken
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_WAIT_INIT = 2'b01,
        ST_ACTIVE = 2'b10
    } sbscd_state_t;

endpackage

// ===== core/sbscd_fmt_bank.sv
// format control register bank with range checks and selection guard
`timescale 1ns/1ps
module sbscd_fmt_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic [2:0] idx_i,
    input wire logic [3:0] wdata_i,
    output logic [3:0] rdata_o,
    // values in force
    output logic custom_o,
    output logic [7:0] taps_o,
    output logic [7:0] seed_o,
    output logic [3:0] check_len_o,
    output logic [3:0] short_len_o
);

    logic [3:0] fmt_q [sbscd_pkg::FMT_REGS];

    function automatic logic [3:0] fmt_reset(input logic [2:0] idx);
        case (idx)
            sbscd_pkg::IDX_TAPS_LO: fmt_reset = sbscd_pkg::RST_TAPS_LO;
            sbscd_pkg::IDX_TAPS_HI: fmt_reset = sbscd_pkg::RST_TAPS_HI;
            sbscd_pkg::IDX_SEED_LO: fmt_reset = sbscd_pkg::RST_SEED_LO;
            sbscd_pkg::IDX_SEED_HI: fmt_reset = sbscd_pkg::RST_SEED_HI;
            sbscd_pkg::IDX_CHECK_LEN: fmt_reset = sbscd_pkg::RST_CHECK_LEN;
            sbscd_pkg::IDX_SHORT_LEN: fmt_reset = sbscd_pkg::RST_SHORT_LEN;
            sbscd_pkg::IDX_RESERVED: fmt_reset = sbscd_pkg::RST_RESERVED;
            default: fmt_reset = sbscd_pkg::RST_SELECT;
        endcase
    endfunction

    // value a register holds after a write of w
    function automatic logic [3:0] fmt_after(input logic [2:0] idx, input logic [3:0] cur, input logic [3:0] w);
        case (idx)
            sbscd_pkg::IDX_CHECK_LEN: fmt_after = (w > sbscd_pkg::CHECK_LEN_MAX) ? cur : w;
            sbscd_pkg::IDX_SHORT_LEN: fmt_after = (w < sbscd_pkg::SHORT_LEN_MIN) ? cur : w;
            sbscd_pkg::IDX_RESERVED: fmt_after = sbscd_pkg::RST_RESERVED;
            sbscd_pkg::IDX_SELECT: begin
                // only all-ones or all-zeros moves the selection
                if (w == sbscd_pkg::SEL_CUSTOM || w == sbscd_pkg::SEL_STANDARD) begin
                    fmt_after = w;
                end else begin
                    fmt_after = cur;
                end
            end
            default: fmt_after = w;
        endcase
    endfunction

    assign rdata_o = wr_i ? fmt_after(idx_i, fmt_q[idx_i], wdata_i) : fmt_q[idx_i];

    genvar gi;
    generate
        for (gi = 0; gi < sbscd_pkg::FMT_REGS; gi++) begin : g_reg
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fmt_q[gi] <= fmt_reset(3'(gi));
                end else if (clr_i) begin
                    fmt_q[gi] <= fmt_reset(3'(gi));
                end else if (wr_i && idx_i == 3'(gi)) begin
                    fmt_q[gi] <= fmt_after(3'(gi), fmt_q[gi], wdata_i);
                end
            end
        end
    endgenerate

    // register contents apply only while the selection is all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            custom_o <= 1'b0;
            taps_o <= {sbscd_pkg::RST_TAPS_HI, sbscd_pkg::RST_TAPS_LO};
            seed_o <= {sbscd_pkg::RST_SEED_HI, sbscd_pkg::RST_SEED_LO};
            check_len_o <= sbscd_pkg::RST_CHECK_LEN;
            short_len_o <= sbscd_pkg::RST_SHORT_LEN;
        end else if (fmt_q[sbscd_pkg::IDX_SELECT] == sbscd_pkg::SEL_CUSTOM) begin
            custom_o <= 1'b1;
            taps_o <= {fmt_q[sbscd_pkg::IDX_TAPS_HI], fmt_q[sbscd_pkg::IDX_TAPS_LO]};
            seed_o <= {fmt_q[sbscd_pkg::IDX_SEED_HI], fmt_q[sbscd_pkg::IDX_SEED_LO]};
            check_len_o <= fmt_q[sbscd_pkg::IDX_CHECK_LEN];
            short_len_o <= fmt_q[sbscd_pkg::IDX_SHORT_LEN];
        end else begin
            custom_o <= 1'b0;
            taps_o <= {sbscd_pkg::RST_TAPS_HI, sbscd_pkg::RST_TAPS_LO};
            seed_o <= {sbscd_pkg::RST_SEED_HI, sbscd_pkg::RST_SEED_LO};
            check_len_o <= sbscd_pkg::RST_CHECK_LEN;
            short_len_o <= sbscd_pkg::RST_SHORT_LEN;
        end
    end

endmodule

// ===== core/sbscd_top.sv
// slave command decoder: addressing, initialization, clear and format control
`timescale 1ns/1ps

// Functional notes
// - each slave owns a 4-bit address; address 0 reaches every slave.
// - no response is sent to a globally addressed command, except to an accepted initialization.
// - bus switch is open after power-up until an initialization is accepted.
// - accepted initialization latches the address and sets the switch from close_req.
// - exactly one initialization response echoes the programmed information.
// - pre-programmed slave uses stored address, ignores everything before initialization.
// - code 0000 is initialization, accepted only on the switch input terminal.
// - code 1111 is reverse initialization, accepted only on the switch output terminal.
// - data low nibble is new address, or must match the stored one.
// - data bit 6 requests switch closure, gated by fault checks.
// - clear 0111 returns to power-up state and standard formatting.
// - format command 1010 is long: flag bit 7, index 6..4, data 3..0.
// - flag 1 writes, flag 0 reads; the value goes into the next response.
// - indices: taps, seed, check length, short length, reserved, selection.
// - taps registers are CRC feedback taps, reset to 0001 each.
// - seed registers preload the CRC, reset to 1010 and 0000.
// - check length 0 to 8, reset 4, larger writes ignored.
// - short payload length 8 to 15, reset 8, smaller writes ignored.
// - custom format starts only on a single write of 1111 to selection.
// - standard format returns on a single write of 0000, or on reset or clear.
// - reset or clear leaves all format registers at standard values.
// - a response goes out during the following command frame.
// - frames with a CRC mismatch are discarded without response.
// - long command is data byte, address, command code, CRC in order.
module sbscd_top #(
    parameter bit ENHANCED = 1'b1
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // address straps (pins)
    input wire logic PREPROG_STRAP,
    input wire logic [3:0] PREPROG_ADDR,
    // internal fault check result for the bus switch
    input wire logic SWITCH_PERMIT,
    // received command frame from the bit receiver
    input wire logic CMD_VALID,
    input wire logic CMD_LONG,
    input wire logic CMD_CRC_OK,
    input wire logic CMD_AT_OUTPUT,
    input wire logic [7:0] CMD_DATA,
    input wire logic [3:0] CMD_ADDR,
    input wire logic [3:0] CMD_CODE,
    // device-specific response from the application
    input wire logic DEV_RSP_VALID,
    input wire logic [15:0] DEV_RSP_DATA,
    // node state
    output logic SWITCH_CLOSED,
    output logic NODE_ACTIVE,
    output logic [3:0] ASSIGNED_NODE_NUMBER,
    // response for the next frame
    output logic RSP_ARM,
    output logic [15:0] RSP_DATA,
    // device-specific command forwarding
    output logic DEV_CMD_VALID,
    output logic DEV_CMD_GLOBAL,
    output logic DEV_CMD_LONG,
    output logic [7:0] DEV_CMD_DATA,
    output logic [3:0] DEV_CMD_CODE,
    // word format in force
    output logic CUSTOM_FORMAT,
    output logic [7:0] CRC_TAPS,
    output logic [7:0] CRC_SEED,
    output logic [3:0] CHECK_LENGTH,
    output logic [3:0] SHORT_PAYLOAD_LENGTH
);

    sbscd_pkg::sbscd_state_t state_q;
    sbscd_pkg::sbscd_state_t state_d;

    logic [4:0] strap_s1_q;
    logic [4:0] strap_s2_q;
    logic [1:0] strap_cnt_q;
    logic preprog_q;
    logic [3:0] strap_addr_q;
    logic [3:0] node_q;
    logic [3:0] node_d;
    logic active_q;
    logic switch_q;
    logic switch_d;
    logic rsp_arm_q;
    logic rsp_arm_d;
    logic [15:0] rsp_data_q;
    logic [15:0] rsp_data_d;
    logic dev_valid_q;
    logic dev_global_q;
    logic dev_long_q;
    logic [7:0] dev_data_q;
    logic [3:0] dev_code_q;

    logic frame_ok;
    logic is_global;
    logic for_me;
    logic init_code;
    logic init_addr_ok;
    logic init_accept;
    logic clear_accept;
    logic fmt_hit;
    logic fmt_wr;
    logic fmt_rd;
    logic dev_hit;
    logic close_req;
    logic [3:0] fmt_rdata;
    logic [3:0] new_node;
    logic [2:0] fmt_idx;

    // true when the address field selects every slave
    function automatic logic addr_global(input logic [3:0] a);
        addr_global = (a == sbscd_pkg::GLOBAL_ADDR);
    endfunction

    // true when the address field selects this slave or every slave
    function automatic logic addr_hits(input logic [3:0] a, input logic [3:0] own);
        addr_hits = addr_global(a) || (a == own);
    endfunction

    // strap pins pass two flops before anything reads them
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            strap_s1_q <= 5'h00;
            strap_s2_q <= 5'h00;
        end else begin
            strap_s1_q <= {PREPROG_STRAP, PREPROG_ADDR};
            strap_s2_q <= strap_s1_q;
        end
    end

    // strap is taken once the synchroniser has filled after release
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            strap_cnt_q <= 2'h0;
            preprog_q <= 1'b0;
            strap_addr_q <= 4'h0;
        end else if (state_q == sbscd_pkg::ST_STRAP) begin
            if (strap_cnt_q == sbscd_pkg::STRAP_WAIT) begin
                preprog_q <= strap_s2_q[4];
                strap_addr_q <= strap_s2_q[3:0];
            end else begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
        end
    end

    // frame decode; bad CRC frames qualify nothing
    assign frame_ok = CMD_VALID && CMD_CRC_OK;
    assign is_global = addr_global(CMD_ADDR);
    assign for_me = addr_hits(CMD_ADDR, node_q);
    assign new_node = CMD_DATA[sbscd_pkg::NIB_HI:sbscd_pkg::NIB_LO];
    assign fmt_idx = CMD_DATA[sbscd_pkg::FMT_IDX_HI:sbscd_pkg::FMT_IDX_LO];

    // each initialization flavour only counts on its own terminal
    assign init_code = (CMD_CODE == sbscd_pkg::CODE_INIT && !CMD_AT_OUTPUT)
        || (CMD_CODE == sbscd_pkg::CODE_REV_INIT && CMD_AT_OUTPUT);

    // pre-programmed: own address and matching nibble; otherwise global
    assign init_addr_ok = preprog_q
        ? (CMD_ADDR == node_q && new_node == node_q)
        : is_global;

    assign init_accept = frame_ok && CMD_LONG && init_code && init_addr_ok
        && state_q == sbscd_pkg::ST_WAIT_INIT;

    assign clear_accept = frame_ok && for_me && CMD_CODE == sbscd_pkg::CODE_CLEAR
        && state_q != sbscd_pkg::ST_STRAP;

    assign fmt_hit = frame_ok && for_me && CMD_LONG && CMD_CODE == sbscd_pkg::CODE_FORMAT
        && state_q == sbscd_pkg::ST_ACTIVE;
    assign fmt_wr = fmt_hit && CMD_DATA[sbscd_pkg::FMT_RW_BIT];
    assign fmt_rd = fmt_hit && !CMD_DATA[sbscd_pkg::FMT_RW_BIT] && !is_global;

    // anything else addressed to an active node belongs to the application
    assign dev_hit = frame_ok && for_me && state_q == sbscd_pkg::ST_ACTIVE
        && CMD_CODE != sbscd_pkg::CODE_FORMAT && CMD_CODE != sbscd_pkg::CODE_CLEAR
        && CMD_CODE != sbscd_pkg::CODE_INIT && CMD_CODE != sbscd_pkg::CODE_REV_INIT;

    // closure request, subject to the fault check in enhanced parts
    assign close_req = ENHANCED
        ? (CMD_DATA[sbscd_pkg::INIT_SWITCH_BIT] && SWITCH_PERMIT)
        : 1'b1;

    // node state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            sbscd_pkg::ST_STRAP: begin
                if (strap_cnt_q == sbscd_pkg::STRAP_WAIT) begin
                    state_d = sbscd_pkg::ST_WAIT_INIT;
                end
            end
            sbscd_pkg::ST_WAIT_INIT: begin
                if (init_accept) begin
                    state_d = sbscd_pkg::ST_ACTIVE;
                end
            end
            sbscd_pkg::ST_ACTIVE: begin
                if (clear_accept) begin
                    state_d = sbscd_pkg::ST_WAIT_INIT;
                end
            end
            default: state_d = sbscd_pkg::ST_STRAP;
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= sbscd_pkg::ST_STRAP;
            active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            active_q <= (state_d == sbscd_pkg::ST_ACTIVE);
        end
    end

    // node address
    always_comb begin
        node_d = node_q;
        if (state_q == sbscd_pkg::ST_STRAP && strap_cnt_q == sbscd_pkg::STRAP_WAIT) begin
            node_d = strap_s2_q[4] ? strap_s2_q[3:0] : sbscd_pkg::GLOBAL_ADDR;
        end else if (clear_accept) begin
            node_d = preprog_q ? strap_addr_q : sbscd_pkg::GLOBAL_ADDR;
        end else if (init_accept) begin
            node_d = new_node;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            node_q <= sbscd_pkg::GLOBAL_ADDR;
        end else begin
            node_q <= node_d;
        end
    end

    // bus switch
    always_comb begin
        switch_d = switch_q;
        if (clear_accept) begin
            switch_d = 1'b0;
        end else if (init_accept) begin
            switch_d = close_req;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            switch_q <= 1'b0;
        end else begin
            switch_q <= switch_d;
        end
    end

    // response for the next frame; any frame ends the one armed before
    always_comb begin
        rsp_arm_d = rsp_arm_q;
        rsp_data_d = rsp_data_q;
        if (CMD_VALID) begin
            rsp_arm_d = 1'b0;
        end
        if (init_accept) begin
            rsp_arm_d = 1'b1;
            rsp_data_d = {CMD_DATA, new_node, CMD_CODE};
        end else if (fmt_wr && !is_global) begin
            rsp_arm_d = 1'b1;
            rsp_data_d = {8'h00, CMD_DATA[sbscd_pkg::FMT_RW_BIT:sbscd_pkg::FMT_IDX_LO], fmt_rdata};
        end else if (fmt_rd) begin
            rsp_arm_d = 1'b1;
            rsp_data_d = {8'h00, CMD_DATA[sbscd_pkg::FMT_RW_BIT:sbscd_pkg::FMT_IDX_LO], fmt_rdata};
        end else if (DEV_RSP_VALID && state_q == sbscd_pkg::ST_ACTIVE && !clear_accept) begin
            rsp_arm_d = 1'b1;
            rsp_data_d = DEV_RSP_DATA;
        end
        if (clear_accept) begin
            rsp_arm_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rsp_arm_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_arm_q <= rsp_arm_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    // application command forwarding, one-cycle pulse
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            dev_valid_q <= 1'b0;
            dev_global_q <= 1'b0;
            dev_long_q <= 1'b0;
            dev_data_q <= 8'h00;
            dev_code_q <= 4'h0;
        end else begin
            dev_valid_q <= dev_hit;
            if (dev_hit) begin
                dev_global_q <= is_global;
                dev_long_q <= CMD_LONG;
                dev_data_q <= CMD_DATA;
                dev_code_q <= CMD_CODE;
            end
        end
    end

    sbscd_fmt_bank u_fmt (
        .clk(MCLK),
        .rst_n(RSTN),
        .clr_i(clear_accept),
        .wr_i(fmt_wr),
        .idx_i(fmt_idx),
        .wdata_i(new_node),
        .rdata_o(fmt_rdata),
        .custom_o(CUSTOM_FORMAT),
        .taps_o(CRC_TAPS),
        .seed_o(CRC_SEED),
        .check_len_o(CHECK_LENGTH),
        .short_len_o(SHORT_PAYLOAD_LENGTH)
    );

    assign SWITCH_CLOSED = switch_q;
    assign NODE_ACTIVE = active_q;
    assign ASSIGNED_NODE_NUMBER = node_q;
    assign RSP_ARM = rsp_arm_q;
    assign RSP_DATA = rsp_data_q;
    assign DEV_CMD_VALID = dev_valid_q;
    assign DEV_CMD_GLOBAL = dev_global_q;
    assign DEV_CMD_LONG = dev_long_q;
    assign DEV_CMD_DATA = dev_data_q;
    assign DEV_CMD_CODE = dev_code_q;

endmodule

// ===== tb/sbscd_master_model.sv
// central master model that issues long command frames to the slave
`timescale 1ns/1ps
module sbscd_master (
    // clock
    input wire logic clk,
    // command frame
    output logic cmd_valid,
    output logic cmd_long,
    output logic cmd_crc_ok,
    output logic cmd_at_output,
    output logic [7:0] cmd_data,
    output logic [3:0] cmd_addr,
    output logic [3:0] cmd_code
);
    initial begin
        cmd_valid = 1'b0;
        cmd_long = 1'b0;
        cmd_crc_ok = 1'b0;
        cmd_at_output = 1'b0;
        cmd_data = 8'h00;
        cmd_addr = 4'h0;
        cmd_code = 4'h0;
    end
    // one frame per call, held for one clock
    task automatic send(input logic ok, outp, input logic [7:0] d, input logic [3:0] a, c);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_long = 1'b1;
        cmd_crc_ok = ok;
        cmd_at_output = outp;
        cmd_data = d;
        cmd_addr = a;
        cmd_code = c;
        @(negedge clk);
        // released lines carry the inverse so no stale frame lingers
        cmd_valid = 1'b0;
        cmd_long = 1'b0;
        cmd_data = ~d;
        cmd_addr = ~a;
        cmd_code = ~c;
    endtask
endmodule

// ===== tb/sbscd_monitor.sv
// concurrent checks on the slave command decoder ports
`timescale 1ns/1ps
module sbscd_monitor (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // command frame, fault check result and application response flag
    input wire logic CMD_VALID,
    input wire logic CMD_CRC_OK,
    input wire logic [7:0] CMD_DATA,
    input wire logic [3:0] CMD_ADDR,
    input wire logic [3:0] CMD_CODE,
    input wire logic SWITCH_PERMIT,
    input wire logic DEV_RSP_VALID,
    // node state and response
    input wire logic SWITCH_CLOSED,
    input wire logic NODE_ACTIVE,
    input wire logic [3:0] ASSIGNED_NODE_NUMBER,
    input wire logic RSP_ARM,
    input wire logic [15:0] RSP_DATA,
    input wire logic CUSTOM_FORMAT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    wire good = CMD_VALID && CMD_CRC_OK && !DEV_RSP_VALID;
    a_clear_resets: assert property (
        good && CMD_CODE == sbscd_pkg::CODE_CLEAR && (CMD_ADDR == 4'h0 || CMD_ADDR == ASSIGNED_NODE_NUMBER)
        |=> !NODE_ACTIVE && !SWITCH_CLOSED && !RSP_ARM) else $error("clear left node state");
    a_bad_crc_quiet: assert property (
        CMD_VALID && !CMD_CRC_OK && !DEV_RSP_VALID
        |=> !RSP_ARM && $stable(NODE_ACTIVE) && $stable(SWITCH_CLOSED)) else $error("bad frame acted on");
    a_global_no_reply: assert property (
        good && CMD_ADDR == 4'h0 && CMD_CODE != sbscd_pkg::CODE_INIT && CMD_CODE != sbscd_pkg::CODE_REV_INIT
        |=> !RSP_ARM) else $error("reply to global command");
    a_init_echo: assert property (
        $rose(NODE_ACTIVE) |-> RSP_ARM && RSP_DATA[11:8] == RSP_DATA[7:4]
        && RSP_DATA == {$past(CMD_DATA), ASSIGNED_NODE_NUMBER, $past(CMD_CODE)}) else $error("bad init echo");
    a_switch_bit: assert property (
        $rose(NODE_ACTIVE) |-> SWITCH_CLOSED == (RSP_DATA[14] && $past(SWITCH_PERMIT)))
        else $error("switch state wrong after init");
    a_custom_enter: assert property (
        $rose(CUSTOM_FORMAT) |-> $past(good, 2) && $past(CMD_DATA, 2) == 8'hFF
        && $past(CMD_CODE, 2) == sbscd_pkg::CODE_FORMAT) else $error("custom format without full write");
    a_custom_leave: assert property (
        $fell(CUSTOM_FORMAT) |-> $past(good, 2) && ($past(CMD_CODE, 2) == sbscd_pkg::CODE_CLEAR
        || $past(CMD_DATA, 2) == 8'hF0 && $past(CMD_CODE, 2) == sbscd_pkg::CODE_FORMAT)) else $error("bad revert");
    a_reply_holds: assert property (
        RSP_ARM && !CMD_VALID && !DEV_RSP_VALID |=> RSP_ARM && $stable(RSP_DATA)) else $error("reply lost");
    cover property ($rose(NODE_ACTIVE));
    cover property ($rose(CUSTOM_FORMAT));
    cover property (good && CMD_CODE == sbscd_pkg::CODE_CLEAR);
endmodule
bind sbscd_top sbscd_monitor sbscd_monitor_inst (.*);

// ===== tb/testbench.sv
// self-checking bench for the slave command decoder
`timescale 1ns/1ps
module testbench;
    logic MCLK = 1'b0, RSTN = 1'b0;
    logic PREPROG_STRAP = 1'b0;
    logic [3:0] PREPROG_ADDR = 4'h5;
    logic SWITCH_PERMIT = 1'b1;
    logic CMD_VALID, CMD_LONG, CMD_CRC_OK, CMD_AT_OUTPUT, SWITCH_CLOSED, NODE_ACTIVE, RSP_ARM, CUSTOM_FORMAT;
    logic [7:0] CMD_DATA, CRC_TAPS, CRC_SEED;
    logic [3:0] CMD_ADDR, CMD_CODE, ASSIGNED_NODE_NUMBER, CHECK_LENGTH, SHORT_PAYLOAD_LENGTH, me;
    logic [15:0] RSP_DATA;
    logic [3:0] ev [8];
    logic [6:0] cor [9] = '{7'h49, 7'h48, 7'h57, 7'h5F, 7'h6F, 7'h77, 7'h7F, 7'h78, 7'h70};
    logic [31:0] lfsr = 32'h1D6A;
    int n_fail = 0, compares = 0;
    always #20 MCLK = ~MCLK;
    sbscd_master sbscd_master_inst (.clk(MCLK), .cmd_valid(CMD_VALID), .cmd_long(CMD_LONG),
        .cmd_crc_ok(CMD_CRC_OK), .cmd_at_output(CMD_AT_OUTPUT), .cmd_data(CMD_DATA), .cmd_addr(CMD_ADDR),
        .cmd_code(CMD_CODE));
    sbscd_top sbscd_top_inst (.MCLK(MCLK), .RSTN(RSTN), .PREPROG_STRAP(PREPROG_STRAP),
        .PREPROG_ADDR(PREPROG_ADDR), .SWITCH_PERMIT(SWITCH_PERMIT), .CMD_VALID(CMD_VALID), .CMD_LONG(CMD_LONG),
        .CMD_CRC_OK(CMD_CRC_OK), .CMD_AT_OUTPUT(CMD_AT_OUTPUT), .CMD_DATA(CMD_DATA), .CMD_ADDR(CMD_ADDR),
        .CMD_CODE(CMD_CODE), .DEV_RSP_VALID(1'b0), .DEV_RSP_DATA(16'h0000), .SWITCH_CLOSED(SWITCH_CLOSED),
        .NODE_ACTIVE(NODE_ACTIVE), .ASSIGNED_NODE_NUMBER(ASSIGNED_NODE_NUMBER), .RSP_ARM(RSP_ARM),
        .RSP_DATA(RSP_DATA), .DEV_CMD_VALID(), .DEV_CMD_GLOBAL(), .DEV_CMD_LONG(), .DEV_CMD_DATA(),
        .DEV_CMD_CODE(), .CUSTOM_FORMAT(CUSTOM_FORMAT), .CRC_TAPS(CRC_TAPS), .CRC_SEED(CRC_SEED),
        .CHECK_LENGTH(CHECK_LENGTH), .SHORT_PAYLOAD_LENGTH(SHORT_PAYLOAD_LENGTH));
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] nxt(input logic [2:0] i, input logic [3:0] o, v);
        case (i)
            3'h4: nxt = (v > 4'h8) ? o : v;
            3'h5: nxt = (v < 4'h8) ? o : v;
            3'h6: nxt = 4'h0;
            3'h7: nxt = ((o == 4'h0 && v == 4'hF) || (o == 4'hF && v == 4'h0)) ? v : o;
            default: nxt = v;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, exp, input string what);
        chk({15'h0, got}, {15'h0, exp}, what);
    endtask
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        @(negedge MCLK);
        RSTN = 1'b0;
        PREPROG_STRAP = strap;
        ev = '{4'h1, 4'h1, 4'hA, 4'h0, 4'h4, 4'h8, 4'h0, 4'h0};
        repeat (6) @(negedge MCLK);
        RSTN = 1'b1;
        repeat (4) @(negedge MCLK);
    endtask
    task automatic cmd(input logic ok, outp, input logic [7:0] d, input logic [3:0] a, c);
        sbscd_master_inst.send(ok, outp, d, a, c);
        @(negedge MCLK);
    endtask
    task automatic std_chk;
        chk({CRC_TAPS, CRC_SEED}, 16'h110A, "standard crc");
        chk({8'h00, CHECK_LENGTH, SHORT_PAYLOAD_LENGTH}, 16'h0048, "standard lengths");
    endtask
    task automatic fmt(input logic wr, input logic [2:0] i, input logic [3:0] v);
        if (wr) ev[i] = nxt(i, ev[i], v);
        cmd(1'b1, 1'b0, {wr, i, v}, me, sbscd_pkg::CODE_FORMAT);
        chk_flag(RSP_ARM, 1'b1, "format reply armed");
        chk(RSP_DATA, {8'h00, wr, i, ev[i]}, "format reply");
        chk_flag(CUSTOM_FORMAT, ev[7] == 4'hF, "custom flag");
        if (ev[7] == 4'hF) begin
            chk({CRC_TAPS, CRC_SEED}, {ev[1], ev[0], ev[3], ev[2]}, "custom crc");
            chk({8'h00, CHECK_LENGTH, SHORT_PAYLOAD_LENGTH}, {8'h00, ev[4], ev[5]}, "custom lengths");
        end else begin
            std_chk();
        end
    endtask
    initial begin
        do_reset(1'b0);
        cmd(1'b1, 1'b0, 8'h40, 4'h3, sbscd_pkg::CODE_FORMAT);
        chk_flag(RSP_ARM, 1'b0, "reply before init");
        cmd(1'b1, 1'b1, 8'h43, 4'h0, sbscd_pkg::CODE_INIT);
        chk_flag(NODE_ACTIVE, 1'b0, "init on output side");
        cmd(1'b1, 1'b0, 8'h43, 4'h0, sbscd_pkg::CODE_REV_INIT);
        chk_flag(NODE_ACTIVE, 1'b0, "reverse init on input side");
        cmd(1'b0, 1'b0, 8'h43, 4'h0, sbscd_pkg::CODE_INIT);
        chk_flag(NODE_ACTIVE, 1'b0, "init with bad check");
        chk_flag(SWITCH_CLOSED, 1'b0, "switch open");
        $display("test refusals done");
        lfsr = step(lfsr);
        me = (lfsr[3:0] == 4'h0) ? 4'h9 : lfsr[3:0];
        cmd(1'b1, 1'b0, {lfsr[7], 1'b1, lfsr[5:4], me}, 4'h0, sbscd_pkg::CODE_INIT);
        chk_flag(NODE_ACTIVE, 1'b1, "node active");
        chk({12'h000, ASSIGNED_NODE_NUMBER}, {12'h000, me}, "address");
        chk_flag(SWITCH_CLOSED, 1'b1, "switch closed");
        chk(RSP_DATA, {lfsr[7], 1'b1, lfsr[5:4], me, me, 4'h0}, "init echo");
        cmd(1'b1, 1'b0, 8'h4E, 4'h0, sbscd_pkg::CODE_INIT);
        chk_flag(RSP_ARM, 1'b0, "second init ignored");
        $display("test init done");
        for (int k = 0; k < 8; k++) fmt(1'b0, k[2:0], 4'h0);
        for (int k = 0; k < 40; k++) begin
            lfsr = step(lfsr);
            if (k < 9) fmt(1'b1, cor[k][6:4], cor[k][3:0]);
            else fmt(lfsr[8], lfsr[6:4], lfsr[3:0]);
        end
        $display("test format done");
        ev[7] = nxt(3'h7, ev[7], 4'hF);
        cmd(1'b1, 1'b0, 8'hFF, 4'h0, sbscd_pkg::CODE_FORMAT);
        chk_flag(RSP_ARM, 1'b0, "global write reply");
        fmt(1'b0, 3'h7, 4'h0);
        cmd(1'b1, 1'b0, 8'h00, 4'h0, sbscd_pkg::CODE_CLEAR);
        chk({12'h000, NODE_ACTIVE, SWITCH_CLOSED, RSP_ARM, CUSTOM_FORMAT}, 16'h0000, "after clear");
        std_chk();
        cmd(1'b1, 1'b0, 8'h40, me, sbscd_pkg::CODE_FORMAT);
        chk_flag(RSP_ARM, 1'b0, "reply after clear");
        $display("test clear done");
        do_reset(1'b1);
        me = 4'h5;
        chk({12'h000, ASSIGNED_NODE_NUMBER}, 16'h0005, "stored address");
        SWITCH_PERMIT = 1'b0;
        cmd(1'b1, 1'b1, 8'h45, 4'h0, sbscd_pkg::CODE_REV_INIT);
        chk_flag(NODE_ACTIVE, 1'b0, "global init to stored node");
        cmd(1'b1, 1'b1, 8'h44, 4'h5, sbscd_pkg::CODE_REV_INIT);
        chk_flag(NODE_ACTIVE, 1'b0, "address mismatch");
        cmd(1'b1, 1'b1, 8'h45, 4'h5, sbscd_pkg::CODE_REV_INIT);
        chk({NODE_ACTIVE, SWITCH_CLOSED, 14'h0000}, 16'h8000, "fault gated switch");
        chk(RSP_DATA, 16'h455F, "reverse init echo");
        SWITCH_PERMIT = 1'b1;
        $display("test preprogrammed done");
        conclude();
    end
    initial begin
        repeat (5000) @(posedge MCLK);
        n_fail++;
        $display("Error %0t: watchdog expired", $time);
        conclude();
    end
endmodule
